// ===== prom_cfg.svh
// Purpose: constants for the serial configuration memory loader
// Assumes: system clock period of 5 ns
// Notes:   timing counts are derived from the printed times
`ifndef PROM_CFG_SVH
`define PROM_CFG_SVH

`define PROM_CLK_NS       5
`define PROM_SK_SLOW_NS   4000
`define PROM_SK_FAST_NS   800
// half serial clock periods in system cycles
`define PROM_HALF_SLOW    ((`PROM_SK_SLOW_NS / 2) / `PROM_CLK_NS)
`define PROM_HALF_FAST    ((`PROM_SK_FAST_NS / 2) / `PROM_CLK_NS)
`define PROM_SPEED_SLOW   2'b11
`define PROM_SPEED_FAST   2'b00
`define PROM_READ_OP      3'b110
`define PROM_OP_BITS      3
`define PROM_DATA_BITS    16
`define PROM_SYNC_SETTLE  2'h2
`define PROM_HALF_W       11

`endif

// ===== prom_pkg.sv
// Purpose: shared types of the configuration loader
// Assumes: nothing beyond the constants header
// Notes:   host bus width and loader state encodings
package prom_pkg;

  typedef enum logic [1:0] {
    BUS_8,
    BUS_16,
    BUS_32
  } bus_mode_t;

  typedef enum logic [2:0] {
    S_SETTLE,
    S_CMD,
    S_DATA,
    S_GAP,
    S_DONE
  } load_state_t;

endpackage : prom_pkg

// ===== prom_clk_div.sv
// Purpose: serial memory clock divider with edge enables
// Assumes: half period count held stable while enabled
// Notes:   clock idles low; first rise comes half a period after enable
`timescale 1ns/1ps
`include "prom_cfg.svh"

module prom_clk_div #(
  parameter int HALF_W = `PROM_HALF_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              en,
  input  wire logic [HALF_W-1:0] half_cnt,
  output logic                   sk,
  output logic                   rise,
  output logic                   fall
);

  logic [HALF_W-1:0] cnt_q;
  logic [HALF_W-1:0] cnt_d;
  logic              sk_q;
  logic              sk_d;
  logic              wrap;

  // refused at elaboration: a one-bit counter cannot mark a half period
  if (HALF_W < 2) begin : g_bad_half
    $error("prom_clk_div: HALF_W too small");
  end

  // wrap marks the end of each half period
  always_comb begin
    wrap  = en && (cnt_q == half_cnt - 1'b1);
    cnt_d = wrap || !en ? '0 : cnt_q + 1'b1;
    sk_d  = !en ? 1'b0 : (wrap ? !sk_q : sk_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      sk_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sk_q  <= sk_d;
    end
  end

  assign sk   = sk_q;
  assign rise = wrap && !sk_q;
  assign fall = wrap && sk_q;

endmodule : prom_clk_div

// ===== prom_loader.sv
// Purpose: load power-up configuration words from a serial memory
// Assumes: three-wire read protocol, data changes after serial clock rise
// Notes:   straps are caught once after reset; words stream out as pulses
`timescale 1ns/1ps
`include "prom_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// RL1: strap high means memory fitted; serial interface runs.
// RL2: strap low or open means no memory; nothing is loaded.
// RL3: bus speed 11 gives a 4 us serial clock cycle.
// RL4: bus speed 00 gives an 800 ns serial clock cycle.
// RL5: generated serial clock shifts configuration data out of memory.
// RL6: output pin carries command and address into the memory.
// RL7: with memory fitted, input pin bits are sampled as data.
// RL8: without memory, input pin is bus width strap: low 8, high 16. With HOST_BUS_32 set, the pin is ignored and the mode is always BUS_32.
// RL9: straps sampled once after reset release, held until next reset.
module prom_loader
  import prom_pkg::*;
#(
  parameter int       ADDR_BITS   = 6,
  parameter int       NUM_WORDS   = 8,
  parameter bit       HOST_BUS_32 = 1'b0
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 SYS_RST,
  input  wire logic                 PROM_PRESENT_STRAP,
  input  wire logic                 SERIAL_PROM_IN,
  input  wire logic [1:0]           ONCHIP_BUS_SPEED_CTRL,
  output logic                      SERIAL_PROM_CLOCK,
  output logic                      SERIAL_PROM_OUT,
  output logic                      PROM_CHIP_SELECT,
  output logic [15:0]               CFG_WORD,
  output logic [ADDR_BITS-1:0]      CFG_ADDR,
  output logic                      CFG_VALID,
  output logic                      LOAD_DONE,
  output logic                      PROM_FITTED,
  output prom_pkg::bus_mode_t       BUS_MODE
);
  import prom_pkg::*;

  localparam int CMD_W = `PROM_OP_BITS + ADDR_BITS;
  localparam logic [`PROM_HALF_W-1:0] HALF_SLOW = `PROM_HALF_W'(`PROM_HALF_SLOW);
  localparam logic [`PROM_HALF_W-1:0] HALF_FAST = `PROM_HALF_W'(`PROM_HALF_FAST);
  localparam int SLOW_PER = 2 * `PROM_HALF_SLOW - 1;
  localparam int FAST_PER = 2 * `PROM_HALF_FAST - 1;

  // refused at elaboration: word count beyond the address space, or a
  // command longer than the five-bit bit counter can step through
  if (NUM_WORDS < 1 || NUM_WORDS > (1 << ADDR_BITS) || CMD_W > 32) begin : g_bad_size
    $error("prom_loader: word count or address width not supported");
  end

  // undocumented speeds fall back to the slow clock, the safe choice
  function automatic logic [`PROM_HALF_W-1:0] half_for(input logic [1:0] spd);
    half_for = (spd == `PROM_SPEED_FAST) ? HALF_FAST : HALF_SLOW;
  endfunction : half_for

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  logic [1:0] strap_sync_q;
  logic [1:0] din_sync_q;
  logic       strap_s;
  logic       din_s;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      strap_sync_q <= 2'h0;
      din_sync_q   <= 2'h0;
    end else begin
      strap_sync_q <= {strap_sync_q[0], PROM_PRESENT_STRAP};
      din_sync_q   <= {din_sync_q[0], SERIAL_PROM_IN};
    end
  end

  assign strap_s = strap_sync_q[1];
  assign din_s   = din_sync_q[1];

  //////////////////////////////////////////////////////////////////////////
  // loader state
  load_state_t               state_q, state_d;
  logic [1:0]                settle_q, settle_d;
  logic                      fitted_q, fitted_d;
  bus_mode_t                 mode_q, mode_d;
  logic [`PROM_HALF_W-1:0]   half_q, half_d;
  logic [4:0]                bit_q, bit_d;
  logic [ADDR_BITS-1:0]      addr_q, addr_d;
  logic [15:0]               shift_q, shift_d;
  logic [15:0]               word_q, word_d;
  logic                      valid_q, valid_d;
  logic                      cs_q, cs_d;
  logic                      do_q, do_d;
  logic                      sk;
  logic                      rise;
  logic                      fall;
  logic [CMD_W-1:0]          cmd;

  assign cmd = {`PROM_READ_OP, addr_q};

  // serial clock only runs while words are being fetched, the gap after each word, the last one too, included
  prom_clk_div #(
    .HALF_W   (`PROM_HALF_W)
  ) u_div (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .en       (state_q == S_CMD || state_q == S_DATA || state_q == S_GAP),
    .half_cnt (half_q),
    .sk       (sk),
    .rise     (rise),
    .fall     (fall)
  );

  // sequencer: command bits change on falls, data sampled on rises
  always_comb begin
    state_d  = state_q;
    settle_d = settle_q;
    fitted_d = fitted_q;
    mode_d   = mode_q;
    half_d   = half_q;
    bit_d    = bit_q;
    addr_d   = addr_q;
    shift_d  = shift_q;
    word_d   = word_q;
    valid_d  = 1'b0;
    cs_d     = cs_q;
    do_d     = do_q;
    unique case (state_q)
      S_SETTLE: begin
        settle_d = settle_q + 2'h1;
        // wait out the synchroniser before catching the straps
        if (settle_q == `PROM_SYNC_SETTLE) begin
          fitted_d = strap_s;                                     // RL9
          half_d   = half_for(ONCHIP_BUS_SPEED_CTRL);             // RL3 RL4
          if (HOST_BUS_32)
            mode_d = BUS_32;
          else
            mode_d = (!strap_s && din_s) ? BUS_16 : BUS_8;        // RL8
          if (strap_s) begin
            state_d = S_CMD;                                      // RL1
            cs_d    = 1'b1;
            do_d    = 1'b1;
            bit_d   = 5'h0;
          end else begin
            state_d = S_DONE;                                     // RL2
          end
        end
      end
      S_CMD: begin
        if (rise) begin
          bit_d = bit_q + 5'h1;
          if (bit_q == 5'(CMD_W - 1)) begin
            state_d = S_DATA;
            bit_d   = 5'h0;
          end
        end else if (fall) begin
          do_d = cmd[CMD_W - 1 - int'(bit_q)];                    // RL6
        end
      end
      S_DATA: begin
        if (fall)
          do_d = 1'b0;
        if (rise) begin
          // first rise carries the memory's leading dummy zero
          shift_d = {shift_q[14:0], din_s};                       // RL5 RL7
          bit_d   = bit_q + 5'h1;
          if (bit_q == 5'(`PROM_DATA_BITS)) begin
            word_d  = {shift_q[14:0], din_s};
            valid_d = 1'b1;
            cs_d    = 1'b0;
            bit_d   = 5'h0;
            state_d = S_GAP;
          end
        end
      end
      S_GAP: begin
        // select low through one more rise and the fall after it; leaving on a
        // fall keeps select from rising with the clock and stops it low, no runt
        if (rise)
          bit_d = 5'h1;
        if (fall && bit_q == 5'h1) begin
          if (addr_q == ADDR_BITS'(NUM_WORDS - 1)) begin
            state_d = S_DONE;
          end else begin
            addr_d  = addr_q + 1'b1;
            state_d = S_CMD;
            cs_d    = 1'b1;
            do_d    = 1'b1;
            bit_d   = 5'h0;
          end
        end
      end
      S_DONE: begin
        cs_d = 1'b0;
        do_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q  <= S_SETTLE;
      settle_q <= 2'h0;
      fitted_q <= 1'b0;
      mode_q   <= BUS_8;
      half_q   <= HALF_SLOW;
      bit_q    <= 5'h0;
      addr_q   <= '0;
      shift_q  <= 16'h0000;
      word_q   <= 16'h0000;
      valid_q  <= 1'b0;
      cs_q     <= 1'b0;
      do_q     <= 1'b0;
    end else begin
      state_q  <= state_d;
      settle_q <= settle_d;
      fitted_q <= fitted_d;
      mode_q   <= mode_d;
      half_q   <= half_d;
      bit_q    <= bit_d;
      addr_q   <= addr_d;
      shift_q  <= shift_d;
      word_q   <= word_d;
      valid_q  <= valid_d;
      cs_q     <= cs_d;
      do_q     <= do_d;
    end
  end

  // outputs straight from flops, except LOAD_DONE, decoded from state_q
  assign SERIAL_PROM_CLOCK = sk;
  assign SERIAL_PROM_OUT   = do_q;
  assign PROM_CHIP_SELECT  = cs_q;
  assign CFG_WORD          = word_q;
  assign CFG_ADDR          = addr_q;
  assign CFG_VALID         = valid_q;
  assign LOAD_DONE         = (state_q == S_DONE);
  assign PROM_FITTED       = fitted_q;
  assign BUS_MODE          = mode_q;

  //////////////////////////////////////////////////////////////////////////
  // helper: cycles since the last serial clock rise
  logic [11:0] per_q;
  logic        seen_q;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      per_q  <= 12'h000;
      seen_q <= 1'b0;
    end else begin
      per_q  <= rise ? 12'h000 : per_q + 12'h001;
      seen_q <= (seen_q || rise) && (state_q != S_SETTLE);
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  absent_no_select_a: assert property (                           // RL2
    (state_q != S_SETTLE && !fitted_q) |-> !PROM_CHIP_SELECT && !SERIAL_PROM_CLOCK)
    else $error("memory absent but interface active");

  fitted_select_a: assert property (                              // RL1
    ($past(state_q) == S_SETTLE && state_q != S_SETTLE && fitted_q) |-> PROM_CHIP_SELECT)
    else $error("memory fitted but select not raised");

  slow_period_a: assert property (                                // RL3
    (rise && seen_q && half_q == HALF_SLOW) |-> per_q == 12'(SLOW_PER))
    else $error("slow serial clock cycle wrong");

  fast_period_a: assert property (                                // RL4
    (rise && seen_q && half_q == HALF_FAST) |-> per_q == 12'(FAST_PER))
    else $error("fast serial clock cycle wrong");

  shift_on_rise_a: assert property (                              // RL5
    $changed(shift_q) |-> $past(rise))
    else $error("data shifted without a serial clock rise");

  out_on_fall_a: assert property (                                // RL6
    $changed(SERIAL_PROM_OUT) |-> $past(fall) || $past(rise) || $past(state_q) == S_SETTLE)
    else $error("serial output changed off a clock edge");

  word_last_bit_a: assert property (                              // RL7
    CFG_VALID |-> CFG_WORD[0] == $past(din_s) && !PROM_CHIP_SELECT)
    else $error("loaded word does not end with sampled bit");

  width_strap_a: assert property (                                // RL8
    ($past(state_q) == S_SETTLE && state_q != S_SETTLE && !fitted_q && !HOST_BUS_32)
    |-> BUS_MODE == ($past(din_s) ? BUS_16 : BUS_8))
    else $error("bus width strap misread");

  straps_held_a: assert property (                                // RL9
    (state_q != S_SETTLE && $past(state_q) != S_SETTLE) |-> $stable(fitted_q) && $stable(mode_q))
    else $error("strap values changed after capture");

  fitted_load_c: cover property (fitted_q && $rose(LOAD_DONE));
  absent_load_c: cover property (!fitted_q && $rose(LOAD_DONE));
  word_seen_c:   cover property (CFG_VALID && fitted_q);
  mode16_c:      cover property (BUS_MODE == BUS_16);

endmodule : prom_loader

// ===== prom_mem_model.sv
// Purpose: behavioural serial configuration memory, three-wire read only
// Assumes: read opcode 110, address msb first, data changes after clock rise
// Notes:   a released data line falls to the pin's pull-down level
`timescale 1ns/1ps

module prom_mem_model #(
  parameter int ADDR_BITS = 6
) (
  input  wire logic cs,
  input  wire logic sk,
  input  wire logic di,
  output logic      data_out
);
  localparam int CW = 3 + ADDR_BITS;
  logic [15:0]   mem [2**ADDR_BITS];
  logic [CW-1:0] cmd_q;
  logic [CW-1:0] full;
  logic [15:0]   sel;
  logic [15:0]   word_q;
  int            rises;

  //////////////////////////////////////////////////////////////////////////////
  // the last command bit completes the address
  assign full = {cmd_q[CW-2:0], di};
  assign sel  = mem[full[ADDR_BITS-1:0]];

  // a bad opcode answers inverted data, so a wrong command shows downstream
  always @(posedge sk or negedge cs) begin
    if (!cs) begin
      rises    <= 0;
      data_out <= 1'b0; // pull-down once deselected
    end else begin
      rises <= rises + 1;
      cmd_q <= full;
      if (rises == CW - 1) begin
        word_q   <= (full[CW-1 -: 3] == 3'b110) ? sel : ~sel;
        data_out <= 1'b0;
      end else if (rises >= CW) begin
        data_out <= word_q[15];
        word_q   <= {word_q[14:0], 1'b0};
      end
    end
  end
endmodule : prom_mem_model

// ===== tb_top.sv
// Purpose: self-checking bench for the configuration loader
// Assumes: loader built with four words and six address bits
// Notes:   the slow load is cut by a fresh reset after its first word
`timescale 1ns/1ps

module tb_top;
  import prom_pkg::*;
  localparam int NW = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap_q = 1'b0;
  logic        pin_q = 1'b0;
  logic [1:0]  spd_q = 2'b00;
  logic        mem_do, prom_in, sk, sdo, cs, vld, done, fitted;
  logic [15:0] word;
  logic [5:0]  addr;
  bus_mode_t   mode;
  logic [21:0] exp_q [$];
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  int          cs_rises = 0;
  int          seed = 32'h0899553A;
  real         half_ns = 400.0;
  real         t_rise = -1.0E9;

  always #2.5 clk = ~clk;
  // without a memory the pin is a plain strap level
  assign prom_in = strap_q ? mem_do : pin_q;

  prom_loader #(.ADDR_BITS(6), .NUM_WORDS(NW), .HOST_BUS_32(1'b0)) uut (
    .CLK_SYS(clk), .SYS_RST(rst), .PROM_PRESENT_STRAP(strap_q),
    .SERIAL_PROM_IN(prom_in), .ONCHIP_BUS_SPEED_CTRL(spd_q),
    .SERIAL_PROM_CLOCK(sk), .SERIAL_PROM_OUT(sdo), .PROM_CHIP_SELECT(cs),
    .CFG_WORD(word), .CFG_ADDR(addr), .CFG_VALID(vld), .LOAD_DONE(done),
    .PROM_FITTED(fitted), .BUS_MODE(mode));

  prom_mem_model #(.ADDR_BITS(6)) prom (.cs(cs), .sk(sk), .di(sdo), .data_out(mem_do));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // one load from reset; late strap and speed changes must be ignored
  task automatic run(input logic strap, input logic pin, input logic [1:0] spd,
                     input int nw, input logic full_load);
    @(posedge clk);
    rst     <= 1'b1;
    strap_q <= strap;
    pin_q   <= pin;
    spd_q   <= spd;
    half_ns = (spd == 2'b11) ? 2000.0 : 400.0;
    t_rise  = -1.0E9;
    for (int i = 0; i < nw; i++) exp_q.push_back({6'(i), prom.mem[i]});
    repeat (10) @(posedge clk);
    cs_rises = 0;
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    spd_q <= ~spd;
    pin_q <= ~pin;
    if (!strap) strap_q <= 1'b1;
    while (exp_q.size() != 0 || (full_load && done !== 1'b1)) @(posedge clk);
    repeat (3) @(posedge clk);
    check(22'(fitted), 22'(strap));
    if (strap && full_load) check(22'(cs_rises), 22'(nw));
    if (!strap) begin
      check(22'(mode), pin ? 22'(BUS_16) : 22'(BUS_8));
      check(22'(cs_rises), 22'(0));
    end
  endtask : run

  //////////////////////////////////////////////////////////////////////////////
  // words are matched in arrival order against the driver's notes
  always @(posedge clk) begin
    cycles++;
    if (vld === 1'b1) begin
      if (exp_q.size() == 0) check(22'(0), 22'h3FFFFF);
      else check({addr, word}, exp_q.pop_front());
    end
    if (cycles == 60000) begin
      miscompares++;
      complete_run();
    end
  end

  // clock shape; rises across a reset are far apart, so only close rises compare
  always @(posedge sk) if (!rst) begin
    if ($realtime - t_rise < 3.0 * half_ns)
      check(22'($rtoi($realtime - t_rise)), 22'($rtoi(2.0 * half_ns)));
    t_rise = $realtime;
  end

  always @(negedge sk) if (!rst) begin
    check(22'($rtoi($realtime - t_rise)), 22'($rtoi(half_ns)));
  end

  always @(posedge cs) cs_rises++;

  initial begin
    for (int i = 0; i < 64; i++) prom.mem[i] = 16'($random(seed));
    run(1'b1, 1'b0, 2'b00, NW, 1'b1); // fast, every word
    run(1'b1, 1'b1, 2'b11, 1, 1'b0); // slow, reset in mid-load
    run(1'b0, 1'b0, 2'b00, 0, 1'b1); // absent, narrow bus
    run(1'b0, 1'b1, 2'b11, 0, 1'b1); // absent, wide bus
    complete_run();
  end
endmodule : tb_top
